/* File: design/twb_pkg.sv */
package twb_pkg;

  // ------------------------------------------------------------
  // widths and timing counts (memory-bus clocks)
  // ------------------------------------------------------------
  localparam int TWB_CODE_W = 6;
  localparam int TWB_DIV_W = 16;
  localparam logic [15:0] TWB_HOLD_BASE_CLK = 16'h0008;
  localparam logic [15:0] TWB_HOLD_UNIT_CLK = 16'h0010;
  localparam logic [15:0] TWB_STOP_SETUP_CLK = 16'h0004;
  localparam logic [15:0] TWB_START_LIM_LO = 16'h0010;
  localparam logic [15:0] TWB_START_LIM_HI = 16'h0013;
  localparam int TWB_START_DIV_SHIFT = 4;
  localparam int TWB_START_MAX_SHIFTS = 16;

  // ------------------------------------------------------------
  // divider value per selection code, index order
  // ------------------------------------------------------------
  localparam logic [15:0] TWB_DIV_LUT [64] = '{
    16'h0120, 16'h0140, 16'h0180, 16'h01C0, 16'h0240, 16'h0280, 16'h0300, 16'h0380,
    16'h0480, 16'h0500, 16'h0600, 16'h0700, 16'h0900, 16'h0A00, 16'h0C00, 16'h0E00,
    16'h1200, 16'h1400, 16'h1800, 16'h1C00, 16'h2400, 16'h2800, 16'h3000, 16'h3800,
    16'h4800, 16'h5000, 16'h6000, 16'h7000, 16'h9000, 16'hA000, 16'hC000, 16'hF000,
    16'h00A0, 16'h00C0, 16'h00E0, 16'h0100, 16'h0140, 16'h0180, 16'h01E0, 16'h0200,
    16'h0280, 16'h0300, 16'h03C0, 16'h0400, 16'h0500, 16'h0600, 16'h0780, 16'h0800,
    16'h0A00, 16'h0C00, 16'h0F00, 16'h1000, 16'h1400, 16'h1800, 16'h1E00, 16'h2000,
    16'h2800, 16'h3000, 16'h3C00, 16'h4000, 16'h5000, 16'h6000, 16'h7800, 16'h8000
  };

  // ------------------------------------------------------------
  // commands, states, carriers
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    TWB_OP_START = 2'h0,
    TWB_OP_STOP = 2'h1,
    TWB_OP_WRITE = 2'h2,
    TWB_OP_READ = 2'h3
  } twb_op_e;

  typedef struct packed {
    twb_op_e op;
    logic data;
  } twb_cmd_s;

  typedef enum logic [2:0] {
    TWB_ST_IDLE = 3'b000,
    TWB_ST_START = 3'b001,
    TWB_ST_LOW = 3'b010,
    TWB_ST_HIGH = 3'b011,
    TWB_ST_RS_HI = 3'b100,
    TWB_ST_STOP_HI = 3'b101
  } twb_state_e;

  typedef struct packed {
    twb_state_e st;
    logic [15:0] cnt;
    logic [15:0] elapsed;
    logic [15:0] hi_run;
    twb_cmd_s cmd;
    logic ready;
    logic done;
    logic rx_bit;
    logic scl_oe;
    logic sda_oe;
    logic scl_o;
    logic sda_o;
    logic [5:0] tick_cnt;
    logic tick;
    logic scl_s1;
    logic scl_s2;
    logic scl_q;
    logic sda_s1;
    logic sda_s2;
    logic sda_q;
  } twb_st_s;

  // ------------------------------------------------------------
  // decode functions
  // ------------------------------------------------------------
  function automatic logic [15:0] twb_div_lut(input logic [5:0] code);
    return TWB_DIV_LUT[code];
  endfunction

  function automatic logic [15:0] twb_hold_clk(input logic [5:0] code);
    logic [15:0] k;
    k = 16'h0001;
    case ({code[5], code[1]})
      2'b10: k = 16'h0001;
      2'b11: k = 16'h0002;
      2'b00: k = 16'h0003;
      default: k = 16'h0004;
    endcase
    return 16'(TWB_HOLD_BASE_CLK + 16'(16'(TWB_HOLD_UNIT_CLK << code[4:2]) * k));
  endfunction

  function automatic logic [15:0] twb_start_hold(input logic [5:0] code);
    logic [15:0] v;
    logic [15:0] lim;
    v = twb_div_lut(code) >> TWB_START_DIV_SHIFT;
    lim = code[5] ? TWB_START_LIM_HI : TWB_START_LIM_LO;
    for (int i = 0; i < TWB_START_MAX_SHIFTS; i++)
    begin
      if (v >= lim)
      begin
        v = v >> 1;
      end
    end
    return v;
  endfunction

endpackage

/* File: design/twb_bit_timing.sv */
// What this block does
// - all bit intervals counted in memory-bus clocks, divider from 6-bit code
// - codes decode to divider values in the table order
// - not every code has its own SCL rate: codes 01 and 24 both decode to divider 0x140
// - master SCL low and high each half divider; data setup half minus hold
// - output data held 8 plus 16 times 2^code[4:2] times k after SCL falls
// - start hold is divider/16 halved until below 16, or 19 when bit 5 set
// - repeated start setup at least divider plus start hold
// - at least 4 clocks stop setup before SDA is released
// - inputs filtered, delayed by rate plus two up to rate times 2 plus one, rate 0 acting as 1; timing uses filtered lines
// - SCL and SDA only pulled low, released otherwise, never driven high
`timescale 1ns/1ps
`default_nettype none

module twb_bit_timing
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // configuration
  input wire logic [5:0] divider_select_code,
  input wire logic [5:0] filter_sample_rate,
  // command port
  input wire logic cmd_valid,
  input wire twb_pkg::twb_cmd_s cmd,
  output logic cmd_ready,
  output logic cmd_done,
  output logic rx_bit,
  // filtered bus view
  output logic scl_qual,
  output logic sda_qual,
  // two-wire pins
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe
);
  import twb_pkg::*;

  // ------------------------------------------------------------
  // divider-derived phase lengths
  // ------------------------------------------------------------
  twb_st_s s_reg;
  twb_st_s s_next;
  logic [15:0] div_value;
  logic [15:0] half_clk;
  logic [15:0] hold_clk;
  logic [15:0] start_hold_clk;
  logic [15:0] rs_setup_clk;
  logic [5:0] tick_period;

  assign div_value = twb_div_lut(divider_select_code);
  assign half_clk = div_value >> 1;
  assign hold_clk = twb_hold_clk(divider_select_code);
  assign start_hold_clk = twb_start_hold(divider_select_code);
  assign rs_setup_clk = 16'(div_value + start_hold_clk);
  assign tick_period = (filter_sample_rate == 6'h00) ? 6'h01 : filter_sample_rate;

  // ------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------
  always_comb
  begin
    s_next = s_reg;
    s_next.done = 1'b0;
    s_next.scl_o = 1'b0;
    s_next.sda_o = 1'b0;
    s_next.elapsed = (s_reg.elapsed == 16'hFFFF) ? s_reg.elapsed : 16'(s_reg.elapsed + 16'h0001);
    s_next.hi_run = !s_reg.scl_q ? 16'h0000 :
      (s_reg.hi_run == 16'hFFFF) ? s_reg.hi_run : 16'(s_reg.hi_run + 16'h0001);
    // held-off phases count only while the filtered clock is high
    if (s_reg.scl_q || s_reg.st == TWB_ST_LOW || s_reg.st == TWB_ST_START)
      s_next.cnt = 16'(s_reg.cnt - 16'h0001);
    // sampling tick, then two agreeing samples qualify a level
    s_next.tick = (s_reg.tick_cnt >= 6'(tick_period - 6'h01));
    s_next.tick_cnt = s_next.tick ? 6'h00 : 6'(s_reg.tick_cnt + 6'h01);
    if (s_reg.tick)
    begin
      s_next.scl_s1 = scl_i;
      s_next.scl_s2 = s_reg.scl_s1;
      s_next.sda_s1 = sda_i;
      s_next.sda_s2 = s_reg.sda_s1;
    end
    if (s_reg.scl_s1 == s_reg.scl_s2)
      s_next.scl_q = s_reg.scl_s2;
    if (s_reg.sda_s1 == s_reg.sda_s2)
      s_next.sda_q = s_reg.sda_s2;
    case (s_reg.st)
      TWB_ST_IDLE:
      begin
        if (cmd_valid && s_reg.ready)
        begin
          s_next.cmd = cmd;
          if (cmd.op == TWB_OP_START && !s_reg.scl_oe)
          begin
            s_next.st = TWB_ST_START;
            s_next.sda_oe = 1'b1;
            s_next.cnt = 16'(start_hold_clk - 16'h0001);
          end
          else
          begin
            s_next.st = TWB_ST_LOW;
            s_next.scl_oe = 1'b1;
            s_next.cnt = 16'(half_clk - 16'h0001);
          end
        end
      end
      TWB_ST_LOW:
      begin
        // data moves only after the hold time, leaving half minus hold as setup
        if (s_reg.elapsed == 16'(hold_clk - 16'h0001))
        begin
          case (s_reg.cmd.op)
            TWB_OP_WRITE: s_next.sda_oe = ~s_reg.cmd.data;
            TWB_OP_STOP: s_next.sda_oe = 1'b1;
            default: s_next.sda_oe = 1'b0;
          endcase
        end
        if (s_reg.cnt == 16'h0000)
        begin
          s_next.scl_oe = 1'b0;
          case (s_reg.cmd.op)
            TWB_OP_START:
            begin
              s_next.st = TWB_ST_RS_HI;
              s_next.cnt = 16'(rs_setup_clk - 16'h0001);
            end
            TWB_OP_STOP:
            begin
              s_next.st = TWB_ST_STOP_HI;
              s_next.cnt = 16'(TWB_STOP_SETUP_CLK - 16'h0001);
            end
            default:
            begin
              s_next.st = TWB_ST_HIGH;
              s_next.cnt = 16'(half_clk - 16'h0001);
            end
          endcase
        end
      end
      TWB_ST_HIGH:
      begin
        // counting waits for the filtered line, so a stretching slave holds us off
        if (s_reg.scl_q && s_reg.cnt == 16'h0000)
        begin
          s_next.rx_bit = s_reg.sda_q;
          s_next.scl_oe = 1'b1;
          s_next.done = 1'b1;
          s_next.st = TWB_ST_IDLE;
        end
      end
      TWB_ST_RS_HI:
      begin
        if (s_reg.scl_q && s_reg.cnt == 16'h0000)
        begin
          s_next.sda_oe = 1'b1;
          s_next.st = TWB_ST_START;
          s_next.cnt = 16'(start_hold_clk - 16'h0001);
        end
      end
      TWB_ST_START:
      begin
        if (s_reg.cnt == 16'h0000)
        begin
          s_next.scl_oe = 1'b1;
          s_next.done = 1'b1;
          s_next.st = TWB_ST_IDLE;
        end
      end
      TWB_ST_STOP_HI:
      begin
        if (s_reg.scl_q && s_reg.cnt == 16'h0000)
        begin
          s_next.sda_oe = 1'b0;
          s_next.done = 1'b1;
          s_next.st = TWB_ST_IDLE;
        end
      end
      default:
      begin
        s_next.st = TWB_ST_IDLE;
      end
    endcase
    if (s_next.st != s_reg.st)
    begin
      s_next.elapsed = 16'h0000;
    end
    s_next.ready = (s_next.st == TWB_ST_IDLE);
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_reg <= '0;
      {s_reg.scl_s1, s_reg.scl_s2, s_reg.scl_q} <= 3'h7;
      {s_reg.sda_s1, s_reg.sda_s2, s_reg.sda_q} <= 3'h7;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign cmd_ready = s_reg.ready;
  assign cmd_done = s_reg.done;
  assign rx_bit = s_reg.rx_bit;
  assign scl_qual = s_reg.scl_q;
  assign sda_qual = s_reg.sda_q;
  assign scl_o = s_reg.scl_o;
  assign scl_oe = s_reg.scl_oe;
  assign sda_o = s_reg.sda_o;
  assign sda_oe = s_reg.sda_oe;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  sequence seq_low_end;
    s_reg.st == TWB_ST_LOW && s_reg.cnt == 16'h0000;
  endsequence

  sequence seq_sda_move_in_low;
    s_reg.st == TWB_ST_LOW && $changed(s_reg.sda_oe);
  endsequence

  sequence seq_start_end;
    s_reg.st == TWB_ST_START && s_reg.cnt == 16'h0000;
  endsequence

  AST_OPEN_DRAIN: assert property (scl_o == 1'b0 && sda_o == 1'b0)
    else $error("two-wire pin driven high");
  AST_LUT_DECODE: assert property (
    (divider_select_code != 6'h20 || div_value == 16'h00A0) &&
    (divider_select_code != 6'h21 || div_value == 16'h00C0) &&
    (divider_select_code != 6'h1F || div_value == 16'hF000) &&
    (divider_select_code != 6'h3F || div_value == 16'h8000))
    else $error("divider decode wrong");
  AST_UNIQUE_RATE: assert property (
    twb_div_lut(divider_select_code) != twb_div_lut(divider_select_code ^ 6'h01))
    else $error("paired codes share a divider");
  AST_LOAD_LOW: assert property (
    s_reg.st == TWB_ST_IDLE && s_reg.ready && cmd_valid && cmd.op == TWB_OP_WRITE
    |=> s_reg.st == TWB_ST_LOW && s_reg.cnt == 16'($past(half_clk) - 16'h0001) && scl_oe)
    else $error("low phase not loaded from divider");
  AST_LOW_HALF: assert property (
    seq_low_end |-> s_reg.elapsed == 16'(half_clk - 16'h0001) ##1 !scl_oe)
    else $error("scl low period not half divider");
  AST_HIGH_HALF: assert property (
    s_reg.st == TWB_ST_HIGH && s_reg.cnt == 16'h0000 && s_reg.scl_q
    |=> scl_oe && cmd_done && s_reg.hi_run >= half_clk)
    else $error("scl high period short");
  AST_DATA_HOLD: assert property (
    seq_sda_move_in_low |-> s_reg.elapsed == hold_clk)
    else $error("data hold time wrong");
  AST_DATA_SETUP: assert property (
    seq_sda_move_in_low |-> 16'(s_reg.cnt + 16'h0001) == 16'(half_clk - hold_clk))
    else $error("data setup time wrong");
  AST_START_HOLD: assert property (
    seq_start_end |-> s_reg.elapsed == 16'(start_hold_clk - 16'h0001) &&
      start_hold_clk < (divider_select_code[5] ? TWB_START_LIM_HI : TWB_START_LIM_LO)
      ##1 scl_oe && cmd_done)
    else $error("start hold time wrong");

  AST_RS_SETUP: assert property (
    $rose(sda_oe) && !scl_oe && $past(s_reg.st) == TWB_ST_RS_HI
    |-> s_reg.hi_run >= rs_setup_clk)
    else $error("repeated start setup short");

  AST_STOP_SETUP: assert property (
    $fell(sda_oe) && !scl_oe |-> s_reg.hi_run >= TWB_STOP_SETUP_CLK && cmd_done)
    else $error("stop setup short");

  AST_FILTER_TICK: assert property (
    $changed(scl_qual) |-> $past(s_reg.tick, 2))
    else $error("filtered scl moved without a sample");

endmodule

`default_nettype wire

/* File: testbench/twb_bus_partner.sv */
`timescale 1ns/1ps
`default_nettype none

module twb_bus_partner
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // resolved clock line
  input wire logic scl_line,
  // bench control
  input wire logic [15:0] stretch_len,
  input wire logic rd_en,
  input wire logic rd_bit,
  // pulls toward ground
  output logic scl_pull,
  output logic sda_pull
);
  logic [15:0] low_cnt_reg;

  // ------------------------------------------------------------
  // slave stretch: holds scl low after each fall, never during high
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      low_cnt_reg <= 16'h0000;
      scl_pull <= 1'b0;
    end
    else if (scl_line)
    begin
      low_cnt_reg <= 16'h0000;
      scl_pull <= 1'b0;
    end
    else
    begin
      low_cnt_reg <= low_cnt_reg + 16'h0001;
      scl_pull <= (low_cnt_reg + 16'h0001) < stretch_len;
    end
  end

  // no start is ever made here, sda only pulled during a read
  assign sda_pull = rd_en && !rd_bit;
endmodule

`default_nettype wire

/* File: testbench/test_two_wire_bit_timing_divider.sv */
`timescale 1ns/1ps
`default_nettype none

module test_two_wire_bit_timing_divider;
  import twb_pkg::*;
  logic sys_clk, rst_b, cmd_valid, scl_i, sda_i, rd_en, rd_bit;
  logic cmd_ready, cmd_done, rx_bit, scl_qual, sda_qual, scl_o, scl_oe, sda_o, sda_oe;
  logic scl_pull, sda_pull;
  logic [5:0] code, rate;
  logic [15:0] stretch_len;
  twb_cmd_s cmd;
  int bad_count, n_compared, seed, dv, half, hold, sh, rt;
  logic q_scl[$], q_sda[$], q_sq[$], q_w[$];
  logic [5:0] codes [13] = '{6'h20, 6'h21, 6'h22, 6'h23, 6'h24, 6'h25, 6'h00, 6'h01,
    6'h02, 6'h03, 6'h27, 6'h2C, 6'h0A};

  // open drain: line low if anyone pulls
  assign scl_i = !(scl_oe | scl_pull);
  assign sda_i = !(sda_oe | sda_pull);

  twb_bit_timing u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .divider_select_code(code),
    .filter_sample_rate(rate), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
    .cmd_done(cmd_done), .rx_bit(rx_bit), .scl_qual(scl_qual), .sda_qual(sda_qual),
    .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o),
    .sda_oe(sda_oe));

  twb_bus_partner u_partner (.sys_clk(sys_clk), .rst_b(rst_b), .scl_line(scl_i),
    .stretch_len(stretch_len), .rd_en(rd_en), .rd_bit(rd_bit), .scl_pull(scl_pull),
    .sda_pull(sda_pull));

  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // ------------------------------------------------------------
  // expectations
  // ------------------------------------------------------------
  function automatic int exp_div(input logic [5:0] c);
    case (c)
      6'h20: return 160;
      6'h21: return 192;
      6'h22: return 224;
      6'h23: return 256;
      6'h24: return 320;
      6'h25: return 384;
      6'h00: return 288;
      6'h01: return 320;
      6'h02: return 384;
      6'h03: return 448;
      6'h27: return 512;
      6'h2C: return 1280;
      6'h0A: return 1536;
      default: return 0;
    endcase
  endfunction

  function automatic int exp_hold(input logic [5:0] c);
    int k;
    k = ({c[5], c[1]} == 2'b10) ? 1 : ({c[5], c[1]} == 2'b11) ? 2 : c[1] ? 4 : 3;
    return 8 + (16 << c[4:2]) * k;
  endfunction

  function automatic int exp_sh(input logic [5:0] c);
    int v;
    v = exp_div(c) / 16;
    while (v >= (c[5] ? 19 : 16))
      v = v >> 1;
    return v;
  endfunction

  function automatic int first(input logic q[$], input int from, input logic v);
    for (int i = from; i < q.size(); i++)
      if (q[i] === v)
        return i;
    return -1000;
  endfunction

  // ------------------------------------------------------------
  // checking and driving
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_compared++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t %s seen %0d exp %0d", $time, msg, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // one command; trace of pins from the cycle after the take
  task automatic run(input twb_op_e op, input logic d);
    int n;
    n = 0;
    q_scl = {};
    q_sda = {};
    q_sq = {};
    q_w = {};
    while (cmd_ready !== 1'b1 && n < 100)
    begin
      @(posedge sys_clk);
      #1 n++;
    end
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd.op <= op;
    cmd.data <= d;
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    // index 0 is the take edge, so index k is k cycles into the command
    n = 0;
    #1;
    while (n < 6000)
    begin
      q_scl.push_back(scl_oe);
      q_sda.push_back(sda_oe);
      q_sq.push_back(scl_qual);
      q_w.push_back(scl_i);
      if (cmd_done === 1'b1)
        break;
      @(posedge sys_clk);
      #1 n++;
    end
    check(32'(cmd_done), 1, "command never finished");
  endtask

  task automatic wr(input logic d);
    int f, w, qh;
    run(TWB_OP_WRITE, d);
    f = first(q_scl, 0, 1'b0);
    check(f, half, "scl low period");
    check(first(q_sda, 0, !d), hold, "data hold");
    w = first(q_w, f, 1'b1);
    qh = first(q_sq, w, 1'b1);
    check(qh - w >= rt + 2 && qh - w <= 2 * rt + 1, 1, "filter delay");
    check(q_scl.size() - 1 - qh >= half && q_scl.size() - 1 - qh <= half + 1, 1, "scl high");
  endtask

  always @(negedge sys_clk)
    if (rst_b === 1'b1)
      check(32'({scl_o, sda_o}), 0, "pin driven high");

  initial
  begin
    // about twice the expected run of the code list
    repeat (90000) @(posedge sys_clk);
    check(0, 1, "watchdog expired");
    print_verdict();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    int f, s, b;
    seed = 25341;
    bad_count = 0;
    n_compared = 0;
    rst_b = 1'b0;
    cmd_valid = 1'b0;
    cmd = '0;
    code = 6'h20;
    rate = 6'h01;
    stretch_len = 16'h0000;
    rd_en = 1'b0;
    rd_bit = 1'b1;
    repeat (16) @(posedge sys_clk);
    check(32'({cmd_ready, scl_oe, sda_oe, scl_qual, sda_qual}), 3, "reset values");
    rst_b <= 1'b1;
    foreach (codes[i])
    begin
      @(posedge sys_clk);
      dv = exp_div(codes[i]);
      half = dv / 2;
      hold = exp_hold(codes[i]);
      sh = exp_sh(codes[i]);
      rt = $unsigned($random(seed)) % 4;
      code <= codes[i];
      rate <= 6'(rt);
      // stretch must outlast the master's own low time to be seen
      stretch_len <= ($random(seed) & 1) ? 16'(half + 20 + $unsigned($random(seed)) % 20) : 16'h0000;
      rt = (rt == 0) ? 1 : rt;
      run(TWB_OP_START, 1'b0);
      check(first(q_scl, 0, 1'b1) - first(q_sda, 0, 1'b1), sh, "start hold");
      wr(1'b1);
      wr(1'b0);
      b = $random(seed) & 1;
      @(posedge sys_clk);
      rd_en <= 1'b1;
      rd_bit <= b[0];
      run(TWB_OP_READ, 1'b1);
      check(32'(rx_bit), 32'(b[0]), "read bit");
      @(posedge sys_clk);
      rd_en <= 1'b0;
      run(TWB_OP_START, 1'b0);
      f = first(q_scl, 0, 1'b0);
      s = first(q_sda, f, 1'b1);
      check(s - f >= dv + sh, 1, "repeated start setup");
      check(first(q_scl, s, 1'b1) - s, sh, "repeated start hold");
      wr(1'b1);
      run(TWB_OP_STOP, 1'b0);
      f = first(q_sq, first(q_scl, 0, 1'b0), 1'b1);
      check(first(q_sda, f, 1'b0) - f >= 4, 1, "stop setup");
      check(32'({q_scl[$], q_sda[$]}), 0, "bus released");
    end
    print_verdict();
  end
endmodule

`default_nettype wire
